// file: pkg/cls_map.svh
// Offsets, field positions, opcode patterns and cycle counts of the
// compact load/store decoder.
// Assumes it is included by bare name after the types package.
// How it works
// - Register-offset: address is base plus offset register; 00 word store, 01 byte store
// - Register-offset: 10 loads a word, 11 loads a byte, same address
// - Sign-extend group: 00 stores data bits 0-15 as half-word
// - Sign-extend group: 01 loads half-word, upper 16 bits cleared
// - Sign-extend group: 10 loads byte, bit 7 copied into bits 8-31
// - Sign-extend group: 11 loads half-word, bit 15 copied into bits 16-31
// - Immediate group: 00 word store, 01 word load, 10 byte store, 11 byte load
// - Immediate word transfers scale the 5-bit offset by four
// - Immediate byte transfers add the 5-bit offset unscaled
// - Half-word immediate doubles the 5-bit offset before adding
// - Half-word immediate: 0 stores bits 0-15, 1 loads with upper bits cleared
// - Half-word immediate uses only the eight low registers
// - Stack-relative: bits 7:0 immediate, 10:8 data register, 11 direction
// - Stack-relative address is stack pointer plus immediate times four
// - Load-address adds constant times four to PC or stack pointer
// - PC source is instruction address plus 4, bit 1 cleared
// - Load-address leaves condition flags unchanged
// - Stack adjust adds a 9-bit signed constant to stack pointer
// - Stack adjust: sign 0 adds, 1 subtracts, flags unchanged
// - Each operation takes the cycles of its full-width equivalent
`ifndef CLS_MAP_SVH
`define CLS_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CLS_OFF_INSTR   8'h00
`define CLS_OFF_PC      8'h04
`define CLS_OFF_STATUS  8'h08
`define CLS_OFF_FLAGS   8'h0c
`define CLS_OFF_EADDR   8'h10
`define CLS_OFF_LOW0    8'h20
`define CLS_OFF_LOW7    8'h3c
`define CLS_OFF_SP      8'h40

// ----------------------------------------------------------------------
// Opcode patterns and status fields
// ----------------------------------------------------------------------
`define CLS_OPC_REGOFF  4'h5
`define CLS_OPC_IMM     3'h3
`define CLS_OPC_HALF    4'h8
`define CLS_OPC_SPREL   4'h9
`define CLS_OPC_LADDR   4'ha
`define CLS_OPC_SPADJ   8'hb0
`define CLS_SP_INDEX    4'h8
`define CLS_ST_BUSY     0
`define CLS_ST_ILLEGAL  1

// ----------------------------------------------------------------------
// Constants and cycle counts
// ----------------------------------------------------------------------
`define CLS_PC_AHEAD    32'h0000_0004
`define CLS_PC_MASK     32'hffff_fffd
`define CLS_CYC_LOAD    2'h2
`define CLS_CYC_STORE   2'h1
`define CLS_CYC_ALU     2'h0
`define CLS_RST_WORD    32'h0000_0000

`endif

// file: pkg/cls_pkg.sv
// Types shared by the compact load/store decoder.
// Assumes nothing of its surroundings.
package cls_pkg;

    typedef enum logic [2:0] {
        CLS_F_NONE,
        CLS_F_REGOFF,
        CLS_F_SIGNX,
        CLS_F_IMM,
        CLS_F_HALF,
        CLS_F_SPREL,
        CLS_F_LADDR,
        CLS_F_SPADJ
    } cls_fmt_e;

    typedef enum logic [1:0] {
        CLS_SZ_BYTE,
        CLS_SZ_HALF,
        CLS_SZ_WORD
    } cls_size_e;

endpackage

// file: src/cls_decode.sv
// Compact load/store decoder with address generation, behind an APB slave.
// Assumes a tightly coupled data memory on pclk that presents load data,
// right-aligned, two cycles after the one-cycle request pulse.
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "cls_map.svh"

module cls_decode (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             mem_req,
    output logic             mem_we,
    output logic      [31:0] mem_addr,
    output logic      [1:0]  mem_size,
    output logic      [31:0] mem_wdata,
    input  wire logic [31:0] mem_rdata,
    output logic             wb_valid,
    output logic      [3:0]  wb_reg,
    output logic      [31:0] wb_data,
    output logic             busy
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [31:0]        low_r [0:7];   // Low general registers
    logic [31:0]        sp_r;
    logic [31:0]        pc_r;          // Address of the launched instruction
    logic [3:0]         flags_r;       // Condition flags, written only by software, never by execution
    logic [15:0]        instr_r;
    cls_pkg::cls_fmt_e  fmt_r;
    cls_pkg::cls_size_e size_r;
    logic               sign_r;
    logic               ld_r;
    logic               wbk_r;
    logic [3:0]         rd_r;
    logic [31:0]        result_r;
    logic [31:0]        ea_r;
    logic [1:0]         cnt_r;
    logic               busy_r;
    logic               illegal_r;
    logic               pready_r;
    logic               pslverr_r;
    logic [31:0]        prdata_r;
    logic               mem_req_r;
    logic               mem_we_r;
    logic [1:0]         mem_size_r;
    logic [31:0]        mem_wdata_r;
    logic               wb_valid_r;
    logic [3:0]         wb_reg_r;
    logic [31:0]        wb_data_r;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    logic        apb_access;
    logic        apb_done;
    logic        wr_ok;
    logic        is_low;
    logic        is_ro;
    logic        mapped;
    logic        launch;
    logic        finish;
    logic [31:0] rd_mux;

    // Access answered one cycle into the access phase
    assign apb_access = psel & penable & ~pready_r;
    assign apb_done   = psel & penable & pready_r;
    assign wr_ok      = apb_done & pwrite & ~pslverr_r;
    assign is_low     = (paddr >= `CLS_OFF_LOW0) && (paddr <= `CLS_OFF_LOW7)
                        && (paddr[1:0] == 2'h0);
    assign is_ro      = (paddr == `CLS_OFF_STATUS) ||
                        (paddr == `CLS_OFF_EADDR);
    assign mapped     = is_low || is_ro || (paddr == `CLS_OFF_INSTR) ||
                        (paddr == `CLS_OFF_PC) || (paddr == `CLS_OFF_FLAGS) ||
                        (paddr == `CLS_OFF_SP);

    // Read multiplexer
    always_comb begin
        rd_mux = 32'h0;
        if (is_low) begin
            rd_mux = low_r[paddr[4:2]];
        end else begin
            case (paddr)
                `CLS_OFF_INSTR:  rd_mux = {16'h0, instr_r};
                `CLS_OFF_PC:     rd_mux = pc_r;
                `CLS_OFF_STATUS: rd_mux = {25'h0, fmt_r, 2'h0,
                                           illegal_r, busy_r};
                `CLS_OFF_FLAGS:  rd_mux = {28'h0, flags_r};
                `CLS_OFF_EADDR:  rd_mux = ea_r;
                `CLS_OFF_SP:     rd_mux = sp_r;
                default:         rd_mux = 32'h0;
            endcase
        end
    end

    // Slave answer; writes other than to read-only registers refused while an instruction executes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= `CLS_RST_WORD;
        end else begin
            pready_r  <= apb_access;
            if (apb_access) begin
                pslverr_r <= ~mapped | (pwrite & busy_r & ~is_ro);
                prdata_r  <= pwrite ? 32'h0 : rd_mux;
            end else if (apb_done) begin
                pslverr_r <= 1'b0;
                prdata_r  <= 32'h0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Instruction decode of the word being written
    // ------------------------------------------------------------------
    logic [15:0]        iw;
    cls_pkg::cls_fmt_e  d_fmt;
    cls_pkg::cls_size_e d_size;
    logic               d_sign;
    logic               d_load;
    logic               d_store;
    logic               d_wb;
    logic [3:0]         d_rd;
    logic [31:0]        d_addr;
    logic [31:0]        d_result;
    logic [31:0]        d_wdata;
    logic [1:0]         d_cyc;
    logic [31:0]        base_v;
    logic [31:0]        offr_v;
    logic [31:0]        src_v;

    assign iw     = pwdata[15:0];
    assign base_v = low_r[iw[5:3]];   // Only low registers reachable
    assign offr_v = low_r[iw[8:6]];

    // Format found from high opcode bits first, fields read after
    always_comb begin
        d_fmt    = cls_pkg::CLS_F_NONE;
        d_size   = cls_pkg::CLS_SZ_WORD;
        d_sign   = 1'b0;
        d_load   = 1'b0;
        d_store  = 1'b0;
        d_wb     = 1'b0;
        d_rd     = {1'b0, iw[2:0]};
        d_addr   = 32'h0;
        d_result = 32'h0;
        src_v    = sp_r;
        if (iw[15:12] == `CLS_OPC_REGOFF && !iw[9]) begin
            d_fmt   = cls_pkg::CLS_F_REGOFF;
            d_addr  = base_v + offr_v;
            d_load  = iw[11];
            d_store = ~iw[11];
            d_size  = iw[10] ? cls_pkg::CLS_SZ_BYTE : cls_pkg::CLS_SZ_WORD;
        end else if (iw[15:12] == `CLS_OPC_REGOFF) begin
            d_fmt  = cls_pkg::CLS_F_SIGNX;
            d_addr = base_v + offr_v;
            case (iw[11:10])
                2'h0: begin
                    d_store = 1'b1;
                    d_size  = cls_pkg::CLS_SZ_HALF;
                end
                2'h1: begin
                    d_load = 1'b1;
                    d_size = cls_pkg::CLS_SZ_HALF;
                end
                2'h2: begin
                    d_load = 1'b1;
                    d_sign = 1'b1;
                    d_size = cls_pkg::CLS_SZ_BYTE;
                end
                default: begin
                    d_load = 1'b1;
                    d_sign = 1'b1;
                    d_size = cls_pkg::CLS_SZ_HALF;
                end
            endcase
        end else if (iw[15:13] == `CLS_OPC_IMM) begin
            d_fmt   = cls_pkg::CLS_F_IMM;
            d_load  = iw[11];
            d_store = ~iw[11];
            if (iw[12]) begin
                d_size = cls_pkg::CLS_SZ_BYTE;
                d_addr = base_v + {27'h0, iw[10:6]};
            end else begin
                d_addr = base_v + {25'h0, iw[10:6], 2'h0};
            end
        end else if (iw[15:12] == `CLS_OPC_HALF) begin
            d_fmt   = cls_pkg::CLS_F_HALF;
            d_size  = cls_pkg::CLS_SZ_HALF;
            d_addr  = base_v + {26'h0, iw[10:6], 1'b0};
            d_load  = iw[11];
            d_store = ~iw[11];
        end else if (iw[15:12] == `CLS_OPC_SPREL) begin
            d_fmt   = cls_pkg::CLS_F_SPREL;
            d_rd    = {1'b0, iw[10:8]};
            d_load  = iw[11];
            d_store = ~iw[11];
            d_addr  = sp_r + {22'h0, iw[7:0], 2'h0};
        end else if (iw[15:12] == `CLS_OPC_LADDR) begin
            d_fmt    = cls_pkg::CLS_F_LADDR;
            d_rd     = {1'b0, iw[10:8]};
            d_wb     = 1'b1;
            if (!iw[11]) begin
                src_v = (pc_r + `CLS_PC_AHEAD) & `CLS_PC_MASK;
            end
            d_result = src_v + {22'h0, iw[7:0], 2'h0};
            d_addr   = d_result;
        end else if (iw[15:8] == `CLS_OPC_SPADJ) begin
            d_fmt    = cls_pkg::CLS_F_SPADJ;
            d_rd     = `CLS_SP_INDEX;
            d_wb     = 1'b1;
            // Sign bit picks add or subtract of magnitude times four
            d_result = iw[7] ? sp_r - {23'h0, iw[6:0], 2'h0}
                             : sp_r + {23'h0, iw[6:0], 2'h0};
            d_addr   = d_result;
        end
    end

    // Store data narrowed to the transfer size, cycle count per kind
    always_comb begin
        d_wdata = low_r[d_rd[2:0]];
        if (d_size == cls_pkg::CLS_SZ_BYTE) begin
            d_wdata = {24'h0, d_wdata[7:0]};
        end else if (d_size == cls_pkg::CLS_SZ_HALF) begin
            d_wdata = {16'h0, d_wdata[15:0]};
        end
        if (d_load) begin
            d_cyc = `CLS_CYC_LOAD;
        end else if (d_store) begin
            d_cyc = `CLS_CYC_STORE;
        end else begin
            d_cyc = `CLS_CYC_ALU;
        end
    end

    assign launch = wr_ok && (paddr == `CLS_OFF_INSTR) && !busy_r &&
                    (d_fmt != cls_pkg::CLS_F_NONE);
    assign finish = busy_r && (cnt_r == 2'h0);

    // ------------------------------------------------------------------
    // Execution control and memory request
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r    <= 1'b0;
            cnt_r     <= 2'h0;
            illegal_r <= 1'b0;
            instr_r   <= 16'h0;
            fmt_r     <= cls_pkg::CLS_F_NONE;
            size_r    <= cls_pkg::CLS_SZ_WORD;
            sign_r    <= 1'b0;
            ld_r      <= 1'b0;
            wbk_r     <= 1'b0;
            rd_r      <= 4'h0;
            result_r  <= `CLS_RST_WORD;
            ea_r      <= `CLS_RST_WORD;
        end else if (wr_ok && paddr == `CLS_OFF_INSTR) begin
            instr_r   <= iw;
            illegal_r <= (d_fmt == cls_pkg::CLS_F_NONE);
            fmt_r     <= d_fmt;
            if (launch) begin
                busy_r   <= 1'b1;
                cnt_r    <= d_cyc;
                size_r   <= d_size;
                sign_r   <= d_sign;
                ld_r     <= d_load;
                wbk_r    <= d_wb | d_load;
                rd_r     <= d_rd;
                result_r <= d_result;
                ea_r     <= d_addr;
            end
        end else if (busy_r) begin
            cnt_r  <= cnt_r - 2'h1;
            busy_r <= ~finish;
        end
    end

    // One-cycle request pulse at launch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_req_r   <= 1'b0;
            mem_we_r    <= 1'b0;
            mem_size_r  <= 2'h0;
            mem_wdata_r <= `CLS_RST_WORD;
        end else begin
            mem_req_r <= launch && (d_load || d_store);
            if (launch) begin
                mem_we_r    <= d_store;
                mem_size_r  <= d_size;
                mem_wdata_r <= d_store ? d_wdata : 32'h0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Write-back with load extension
    // ------------------------------------------------------------------
    logic [31:0] ld_val;
    logic [31:0] wb_val;

    always_comb begin
        case (size_r)
            cls_pkg::CLS_SZ_BYTE:
                ld_val = sign_r ? {{24{mem_rdata[7]}}, mem_rdata[7:0]}
                                : {24'h0, mem_rdata[7:0]};
            cls_pkg::CLS_SZ_HALF:
                ld_val = sign_r ? {{16{mem_rdata[15]}}, mem_rdata[15:0]}
                                : {16'h0, mem_rdata[15:0]};
            default:
                ld_val = mem_rdata;
        endcase
        wb_val = ld_r ? ld_val : result_r;
    end

    // Register file: software writes when idle, write-back at finish;
    // execution writes no flag, so load-address keeps them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) begin
                low_r[i] <= `CLS_RST_WORD;
            end
            sp_r    <= `CLS_RST_WORD;
            pc_r    <= `CLS_RST_WORD;
            flags_r <= 4'h0;
        end else if (finish && wbk_r) begin
            if (rd_r == `CLS_SP_INDEX) begin
                sp_r <= wb_val;
            end else begin
                low_r[rd_r[2:0]] <= wb_val;
            end
        end else if (wr_ok) begin
            if (is_low) begin
                low_r[paddr[4:2]] <= pwdata;
            end else if (paddr == `CLS_OFF_SP) begin
                sp_r <= pwdata;
            end else if (paddr == `CLS_OFF_PC) begin
                pc_r <= pwdata;
            end else if (paddr == `CLS_OFF_FLAGS) begin
                flags_r <= pwdata[3:0];
            end
        end
    end

    // Write-back report pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wb_valid_r <= 1'b0;
            wb_reg_r   <= 4'h0;
            wb_data_r  <= `CLS_RST_WORD;
        end else begin
            wb_valid_r <= finish && wbk_r;
            if (finish && wbk_r) begin
                wb_reg_r  <= rd_r;
                wb_data_r <= wb_val;
            end
        end
    end

    assign prdata    = prdata_r;
    assign pready    = pready_r;
    assign pslverr   = pslverr_r;
    assign mem_req   = mem_req_r;
    assign mem_we    = mem_we_r;
    assign mem_addr  = ea_r;
    assign mem_size  = mem_size_r;
    assign mem_wdata = mem_wdata_r;
    assign wb_valid  = wb_valid_r;
    assign wb_reg    = wb_reg_r;
    assign wb_data   = wb_data_r;
    assign busy      = busy_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_load_cycles: assert property ($rose(busy_r) && ld_r |->
        busy_r[*3] ##1 !busy_r)
        else $error("load did not take three cycles");
    a_store_cycles: assert property ($rose(busy_r) && mem_we_r |->
        busy_r[*2] ##1 !busy_r)
        else $error("store did not take two cycles");
    a_req_pulse: assert property (mem_req_r |-> $rose(busy_r)
        ##1 !mem_req_r)
        else $error("request not a launch pulse");
    a_flags_hold: assert property (busy_r |=> $stable(flags_r))
        else $error("flags changed during execution");
    a_la_pc_src: assert property ($rose(busy_r) &&
        fmt_r == cls_pkg::CLS_F_LADDR && !instr_r[11] |->
        result_r == ((pc_r + 32'h4) & 32'hffff_fffd) +
                    {22'h0, instr_r[7:0], 2'h0})
        else $error("load-address PC source wrong");
    a_spadj_result: assert property ($rose(busy_r) &&
        fmt_r == cls_pkg::CLS_F_SPADJ |=>
        sp_r == (instr_r[7] ? $past(sp_r) - {23'h0, instr_r[6:0], 2'h0}
                            : $past(sp_r) + {23'h0, instr_r[6:0], 2'h0}))
        else $error("stack adjust result wrong");
    a_sprel_addr: assert property (mem_req_r &&
        fmt_r == cls_pkg::CLS_F_SPREL |->
        mem_addr == sp_r + {22'h0, instr_r[7:0], 2'h0})
        else $error("stack-relative address wrong");
    a_imm_word_addr: assert property (mem_req_r &&
        fmt_r == cls_pkg::CLS_F_IMM && !instr_r[12] |->
        mem_addr == low_r[instr_r[5:3]] + {25'h0, instr_r[10:6], 2'h0})
        else $error("immediate word offset not scaled");
    a_half_addr: assert property (mem_req_r &&
        fmt_r == cls_pkg::CLS_F_HALF |->
        mem_addr == low_r[instr_r[5:3]] + {26'h0, instr_r[10:6], 1'b0})
        else $error("half-word offset not doubled");
    a_regoff_addr: assert property (mem_req_r &&
        fmt_r == cls_pkg::CLS_F_REGOFF |->
        mem_addr == low_r[instr_r[5:3]] + low_r[instr_r[8:6]])
        else $error("register-offset address wrong");
    a_byte_sext: assert property (finish && ld_r && sign_r &&
        size_r == cls_pkg::CLS_SZ_BYTE |=>
        wb_data_r == {{24{$past(mem_rdata[7])}}, $past(mem_rdata[7:0])})
        else $error("signed byte not extended");

    c_load: cover property ($rose(busy_r) && ld_r ##3 wb_valid_r);
    c_store: cover property (mem_req_r && mem_we_r);
    c_laddr_sp: cover property ($rose(busy_r) &&
        fmt_r == cls_pkg::CLS_F_LADDR && instr_r[11]);
    c_spadj_sub: cover property ($rose(busy_r) &&
        fmt_r == cls_pkg::CLS_F_SPADJ && instr_r[7]);

endmodule

// file: bench/tb.sv
// Self-checking bench: compact load/store decoder driven over APB.
// Assumes cls_pkg compiled first and cls_map.svh on the include path.
`timescale 1ns/100ps
`include "cls_map.svh"

module tb;
    // ------------------------------------------------------------------
    // Stimulus, captured results and expected register file
    // ------------------------------------------------------------------
    localparam logic [31:0] MD = 32'h1234_f08c;
    localparam logic [31:0] SB = {{24{MD[7]}}, MD[7:0]};
    localparam logic [31:0] SH = {{16{MD[15]}}, MD[15:0]};
    localparam logic [31:0] PC = 32'h0000_0102;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic        mem_req, mem_we, wb_valid, busy, m_we, err;
    logic [7:0]  paddr = 8'h00;
    logic [1:0]  mem_size, m_size;
    logic [3:0]  wb_reg, w_reg;
    logic [31:0] pwdata = 32'h0, mem_rdata = MD, prdata, mem_addr;
    logic [31:0] mem_wdata, wb_data, m_addr, m_wdata, w_data, rd;
    logic [31:0] r [0:8];
    int          n_mismatch = 0, comparisons = 0;

    cls_decode dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .wb_valid(wb_valid),
        .wb_reg(wb_reg), .wb_data(wb_data), .busy(busy)
    );

    // Clock at 20 MHz
    initial begin
        forever #25 pclk = ~pclk;
    end

    // Keep the last memory request and the last write-back
    always @(posedge pclk) begin
        if (mem_req === 1'b1) begin
            {m_addr, m_we, m_size, m_wdata} =
                {mem_addr, mem_we, mem_size, mem_wdata};
        end
        if (wb_valid === 1'b1) begin
            {w_reg, w_data} = {wb_reg, wb_data};
        end
    end

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask

    // One APB transfer; holds the request until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16 && pready !== 1'b1; i++) @(posedge pclk);
        if (i == 16) begin
            n_mismatch++;
            tally_and_finish();
        end
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask

    // Launch one instruction; k is 0 store, 1 load, 2 register only
    task automatic run(input logic [15:0] ins, input int k,
                       input logic [31:0] ea, input logic [1:0] sz,
                       input logic [3:0] rg, input logic [31:0] d);
        int n;
        n = 0;
        {m_addr, m_we, m_size, m_wdata, w_reg, w_data} = 'x;
        apb(1'b1, `CLS_OFF_INSTR, {16'h0, ins});
        repeat (12) begin
            @(posedge pclk);
            if (busy === 1'b1) n++;
            else if (n > 0) break;
        end
        @(posedge pclk);
        chk("busy cycles", (k == 0) ? 2 : (k == 1) ? 3 : 1, n);
        if (k < 2) begin
            chk("mem_addr", ea, m_addr);
            chk("mem_we_size", 32'({k == 0, sz}), 32'({m_we, m_size}));
        end
        if (k == 0) chk("mem_wdata", d, m_wdata);
        else begin
            chk("wb_reg", 32'(rg), 32'(w_reg));
            chk("wb_data", d, w_data);
            r[rg] = d;
        end
    endtask

    // Print the counts and the verdict, then stop
    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Reset, load the register file, then one instruction per case
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            r[i] = (i == 8) ? 32'h4000 : 32'h8000_10c0 + 32'h0101_0101 * i;
            apb(1'b1, 8'h20 + 8'(4 * i), r[i]);
        end
        apb(1'b1, `CLS_OFF_PC, PC);
        apb(1'b1, `CLS_OFF_FLAGS, 32'ha);
        apb(1'b1, `CLS_OFF_INSTR, 32'h0);
        apb(1'b0, `CLS_OFF_STATUS, 32'h0);
        chk("illegal", 32'h1, 32'(rd[1]));
        run({4'h5,3'b000,3'd6,3'd2,3'd3},0,r[2]+r[6],2,0,r[3]);
        run({4'h5,3'b010,3'd1,3'd0,3'd5},0,r[0]+r[1],0,0,r[5]&'hff);
        run({4'h5,3'b100,3'd7,3'd4,3'd1},1,r[4]+r[7],2,1,MD);
        run({4'h5,3'b110,3'd2,3'd3,3'd0},1,r[3]+r[2],0,0,MD&'hff);
        run({4'h5,3'b001,3'd0,3'd1,3'd4},0,r[1]+r[0],1,0,r[4]&'hffff);
        run({4'h5,3'b011,3'd5,3'd6,3'd2},1,r[6]+r[5],1,2,MD&'hffff);
        run({4'h5,3'b101,3'd5,3'd6,3'd3},1,r[6]+r[5],0,3,SB);
        run({4'h5,3'b111,3'd1,3'd7,3'd6},1,r[7]+r[1],1,6,SH);
        run({3'h3,2'b00,5'd31,3'd2,3'd3},0,r[2]+124,2,0,r[3]);
        run({3'h3,2'b01,5'd29,3'd5,3'd2},1,r[5]+116,2,2,MD);
        run({3'h3,2'b10,5'd13,3'd0,3'd1},0,r[0]+13,0,0,r[1]&'hff);
        run({3'h3,2'b11,5'd31,3'd6,3'd5},1,r[6]+31,0,5,MD&'hff);
        run({4'h8,1'b0,5'd28,3'd1,3'd6},0,r[1]+56,1,0,r[6]&'hffff);
        run({4'h8,1'b1,5'd31,3'd7,3'd4},1,r[7]+62,1,4,MD&'hffff);
        run({4'h9,1'b0,3'd4,8'd255},0,r[8]+1020,2,0,r[4]);
        run({4'h9,1'b1,3'd7,8'd123},1,r[8]+492,2,7,MD);
        run({4'ha,1'b0,3'd2,8'd143},2,0,0,2,((PC+4)&~32'h2)+572);
        run({4'ha,1'b1,3'd6,8'd53},2,0,0,6,r[8]+212);
        run({8'hb0,1'b0,7'd67},2,0,0,8,r[8]+268);
        run({8'hb0,1'b1,7'd127},2,0,0,8,r[8]-508);
        apb(1'b0, `CLS_OFF_FLAGS, 32'h0);
        chk("flags", 32'ha, rd);
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, 8'h20 + 8'(4 * i), 32'h0);
            chk("register", r[i], rd);
        end
        apb(1'b0, 8'hfc, 32'h0);
        chk("pslverr", 32'h1, 32'(err));
        tally_and_finish();
    end
endmodule
